// ===== hw/pcm_pkg.sv
// Constants shared by the serial voice master port
package pcm_pkg;
    localparam int SAMPLE_W        = 16;
    localparam int FRAME_SLOTS     = 256;
    localparam int SLOT_W          = 8;
    localparam int FIFO_DEPTH      = 8;
    // Link reference clock rate; bench uses a 6 ns period
    localparam int LINK_CLK_KHZ    = 166667;
    localparam int BIT_CLK_HZ      = 2048000;
    localparam int BIT_HALF_CYC    = (LINK_CLK_KHZ * 1000) / (2 * BIT_CLK_HZ);
    localparam int BIT_PER_CYC     = 2 * BIT_HALF_CYC;
    localparam int PHASE_W         = 8;
    localparam int SYNC_LEAD_NS    = 122;
    localparam int SYNC_LEAD_CYC   = (SYNC_LEAD_NS * LINK_CLK_KHZ) / 1000000;
    localparam int ZDOUT_NS        = 160;
    localparam int ZDOUT_CYC       = (ZDOUT_NS * LINK_CLK_KHZ) / 1000000;
    localparam logic [SLOT_W-1:0] SYNC_SLOT  = 8'h00;
    localparam logic [SLOT_W-1:0] FIRST_SLOT = 8'h01;
    localparam logic [SLOT_W-1:0] LAST_SLOT  = 8'h10;
endpackage : pcm_pkg

// ===== hw/pcm_voice_master_port.sv
// Serial voice master port: bit clock, frame sync, sample shifting, FIFO
`timescale 1ns/1ps

module pcm_sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // Depth must be a power of two so the wrap bit marks full
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : pcm_sample_fifo

module pcm_voice_master_port
    import pcm_pkg::*;
#(
    parameter int FIFO_W = pcm_pkg::SAMPLE_W,
    parameter int FIFO_D = pcm_pkg::FIFO_DEPTH
) (
    input  wire logic                         clk,
    input  wire logic                         rstn,
    input  wire logic                         link_clk,
    input  wire logic [pcm_pkg::SAMPLE_W-1:0] tx_data,
    input  wire logic                         tx_valid,
    output logic                              tx_ready,
    output logic                              tx_underrun,
    output logic      [pcm_pkg::SAMPLE_W-1:0] rx_data,
    output logic                              rx_valid,
    output logic                              pcm_bclk,
    output logic                              pcm_sync,
    output logic                              pcm_dout,
    output logic                              pcm_dout_oe,
    input  wire logic                         pcm_din
);
    import pcm_pkg::*;

    // System clock side
    logic                fifo_valid;
    logic [FIFO_W-1:0]   fifo_data;
    logic                req_s1, req_s2, req_s3, req_seen;
    logic                req_evt;
    logic [SAMPLE_W-1:0] tx_hold;
    logic                ack_tgl;
    logic                rxt_s1, rxt_s2, rxt_s3, rxt_seen;
    logic                rxt_evt;

    // Link clock side
    logic                lrst_s1, link_rstn;
    logic [PHASE_W-1:0]  phase, next_phase;
    logic [SLOT_W-1:0]   slot, next_slot;
    logic                rise, fall;
    logic                req_tgl;
    logic                ack_s1, ack_s2, ack_s3, ack_seen;
    logic                ack_evt;
    logic [SAMPLE_W-1:0] tx_next;
    logic [SAMPLE_W-1:0] tx_shift;
    logic                din_s1, din_s2, din_s3, din_f;
    logic [SAMPLE_W-1:0] rx_shift;
    logic [SAMPLE_W-1:0] rx_hold;
    logic                rx_tgl;
    logic                in_data_slot, in_data_next;

    pcm_sample_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_pcm_sample_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_valid),
        .out_ready (req_evt),
        .out_data  (fifo_data)
    );

    // Frame request from the link domain, three-stage sampled
    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_s1   <= 1'b0;
            req_s2   <= 1'b0;
            req_s3   <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_evt) begin
                req_seen <= req_s3;
            end
        end
    end

    assign req_evt = (req_s2 == req_s3) && (req_s3 != req_seen);

    // Hand one word per frame; silence when the queue ran dry
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_hold     <= '0;
            ack_tgl     <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= req_evt && !fifo_valid;
            if (req_evt) begin
                tx_hold <= fifo_valid ? fifo_data : '0;
                ack_tgl <= ~ack_tgl;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rxt_s1   <= 1'b0;
            rxt_s2   <= 1'b0;
            rxt_s3   <= 1'b0;
            rxt_seen <= 1'b0;
        end else begin
            rxt_s1 <= rx_tgl;
            rxt_s2 <= rxt_s1;
            rxt_s3 <= rxt_s2;
            if (rxt_evt) begin
                rxt_seen <= rxt_s3;
            end
        end
    end

    assign rxt_evt = (rxt_s2 == rxt_s3) && (rxt_s3 != rxt_seen);

    // Received word is held a whole frame, so a plain copy is safe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_data  <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= rxt_evt;
            if (rxt_evt) begin
                rx_data <= rx_hold;
            end
        end
    end

    // Reset carried into the link domain
    always_ff @(posedge link_clk) begin
        lrst_s1   <= rstn;
        link_rstn <= lrst_s1;
    end

    // Bit clock divider and slot counter; outputs follow next_ values
    always_comb begin
        if (phase == PHASE_W'(BIT_PER_CYC - 1)) begin
            next_phase = '0;
            next_slot  = slot + 1'b1;
        end else begin
            next_phase = phase + 1'b1;
            next_slot  = slot;
        end
    end

    assign rise = (next_phase == '0);
    assign fall = (next_phase == PHASE_W'(BIT_HALF_CYC));
    assign in_data_slot = (slot >= FIRST_SLOT) && (slot <= LAST_SLOT);
    assign in_data_next = (next_slot >= FIRST_SLOT) &&
                          (next_slot <= LAST_SLOT);

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            // Last phase of the last slot: first high and frame are whole
            phase    <= PHASE_W'(BIT_PER_CYC - 1);
            slot     <= SLOT_W'(FRAME_SLOTS - 1);
            pcm_bclk <= 1'b0;
            pcm_sync <= 1'b0;
        end else begin
            phase    <= next_phase;
            slot     <= next_slot;
            pcm_bclk <= (next_phase < PHASE_W'(BIT_HALF_CYC));
            pcm_sync <=
                ((next_slot == SYNC_SLOT) &&
                 (next_phase >= PHASE_W'(BIT_HALF_CYC - SYNC_LEAD_CYC))) ||
                ((next_slot == FIRST_SLOT) &&
                 (next_phase < PHASE_W'(BIT_HALF_CYC - SYNC_LEAD_CYC)));
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            ack_s1   <= 1'b0;
            ack_s2   <= 1'b0;
            ack_s3   <= 1'b0;
            ack_seen <= 1'b0;
            tx_next  <= '0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
            if (ack_evt) begin
                ack_seen <= ack_s3;
                tx_next  <= tx_hold;
            end
        end
    end

    assign ack_evt = (ack_s2 == ack_s3) && (ack_s3 != ack_seen);

    // One frame of latency: word fetched now goes out next frame
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            req_tgl     <= 1'b0;
            tx_shift    <= '0;
            pcm_dout    <= 1'b0;
            pcm_dout_oe <= 1'b0;
        end else begin
            if (rise && next_slot == SYNC_SLOT) begin
                tx_shift <= tx_next;
                req_tgl  <= ~req_tgl;
            end else if (rise && in_data_next) begin
                pcm_dout    <= tx_shift[SAMPLE_W-1];
                tx_shift    <= {tx_shift[SAMPLE_W-2:0], 1'b0};
                pcm_dout_oe <= 1'b1;
            end
            // Late release keeps hold time at the codec's last sample
            if (next_slot == LAST_SLOT && next_phase ==
                PHASE_W'(BIT_HALF_CYC + ZDOUT_CYC)) begin
                pcm_dout_oe <= 1'b0;
            end
        end
    end

    // Pin filter: a change counts once stages two and three agree
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            din_s3 <= 1'b0;
            din_f  <= 1'b0;
        end else begin
            din_s1 <= pcm_din;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
            if (din_s2 == din_s3) begin
                din_f <= din_s3;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            rx_shift <= '0;
            rx_hold  <= '0;
            rx_tgl   <= 1'b0;
        end else if (fall && in_data_slot) begin
            rx_shift <= {rx_shift[SAMPLE_W-2:0], din_f};
            if (slot == LAST_SLOT) begin
                rx_hold <= {rx_shift[SAMPLE_W-2:0], din_f};
                rx_tgl  <= ~rx_tgl;
            end
        end
    end
endmodule : pcm_voice_master_port

// ===== sim/pcm_port_chk.sv
// Pin timing checks for the voice port
`timescale 1ns/1ps
module pcm_port_chk (
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic pcm_bclk,
    input wire logic pcm_sync,
    input wire logic pcm_dout,
    input wire logic pcm_dout_oe
);
    logic [14:0] gap;
    logic        armed;
    logic [4:0]  bits;
    default clocking @(posedge link_clk);
    endclocking
    default disable iff (!rstn);
    // Armed after the first fall, so the first bclk rise and first sync rise are not judged by a_lo and a_per
    always_ff @(posedge link_clk) begin
        gap   <= (!rstn || $rose(pcm_sync)) ? '0 : gap + 15'h1;
        armed <= rstn & (armed | $fell(pcm_bclk));
    end
    always_ff @(posedge link_clk) begin
        bits <= pcm_dout_oe ? bits + {4'h0, $rose(pcm_bclk)} : 5'h0;
    end
    property p_hi;
        $fell(pcm_bclk) |-> $past(pcm_bclk,40) && !$past(pcm_bclk,41);
    endproperty
    a_hi: assert property (p_hi) else $error("bclk high time");
    property p_lo;
        armed && $rose(pcm_bclk) |-> !$past(pcm_bclk,40) && $past(pcm_bclk,41);
    endproperty
    a_lo: assert property (p_lo) else $error("bclk low time");
    property p_sw;
        $fell(pcm_sync) |-> $past(pcm_sync,80) && !$past(pcm_sync,81);
    endproperty
    a_sw: assert property (p_sw) else $error("sync width");
    property p_per;
        armed && $rose(pcm_sync) |-> gap == 15'h4fff;
    endproperty
    a_per: assert property (p_per) else $error("sync period");
    property p_lead;
        $rose(pcm_sync) |-> pcm_bclk ##20 $fell(pcm_bclk);
    endproperty
    a_lead: assert property (p_lead) else $error("sync lead");
    property p_launch;
        pcm_dout_oe && $changed(pcm_dout) |-> $rose(pcm_bclk);
    endproperty
    a_launch: assert property (p_launch) else $error("dout edge");
    property p_oe_on;
        $rose(pcm_dout_oe) |-> $rose(pcm_bclk) ##20 $fell(pcm_sync);
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("slot start");
    property p_oe_off;
        $fell(pcm_dout_oe) |-> bits == 5'h10
            && $past(pcm_bclk,27) && !$past(pcm_bclk,26);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("release");
endmodule : pcm_port_chk

bind pcm_voice_master_port pcm_port_chk u_pcm_port_chk (
    .link_clk(link_clk), .rstn(rstn), .pcm_bclk(pcm_bclk),
    .pcm_sync(pcm_sync), .pcm_dout(pcm_dout), .pcm_dout_oe(pcm_dout_oe)
);

// ===== sim/pcm_codec_model.sv
// Codec model: slave on the voice lines
`timescale 1ns/1ps
module pcm_codec_model (
    input  wire logic        pcm_bclk,
    input  wire logic        pcm_sync,
    input  wire logic        pcm_dout,
    input  wire logic [15:0] send_word,
    output logic             pcm_din
);
    logic [15:0] shift = '0;
    logic [15:0] got[$];
    int          slot = 300;
    initial pcm_din = 1'b0;
    always @(negedge pcm_bclk) begin
        slot = pcm_sync ? 0 : slot + 1;
        if (slot >= 1 && slot <= 16)
            shift = {shift[14:0], pcm_dout};
        if (slot == 16)
            got.push_back(shift);
    end
    // Outside the slot the line toggles, never a stale bit
    always @(posedge pcm_bclk) begin
        if (slot <= 15)
            pcm_din <= send_word[15 - slot];
        else
            pcm_din <= ~pcm_din;
    end
endmodule : pcm_codec_model

// ===== sim/tb_pcm_voice_master_port.sv
// Bench for the voice port against a codec model
`timescale 1ns/1ps
module tb_pcm_voice_master_port;
    import pcm_pkg::*;
    // Shallow FIFO keeps the drain within a few frames
    localparam int DEPTH = 4;
    localparam logic [15:0] TXW [4] = '{16'h8001, 16'h4002,
                                        16'hff00, 16'h00ff};
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] tx_data = '0;
    logic        tx_valid = 1'b0;
    logic [15:0] codec_word = 16'h8001;
    logic [15:0] rx_data;
    logic        tx_ready, tx_underrun, rx_valid, pcm_din;
    logic        pcm_bclk, pcm_sync, pcm_dout, pcm_dout_oe;
    int          fails = 0;
    int          compares = 0;

    always #5 clk = ~clk;
    initial #1.3 forever #3 link_clk = ~link_clk;

    pcm_voice_master_port #(.FIFO_D(DEPTH)) u_pcm_voice_master_port (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_underrun(tx_underrun),
        .rx_data(rx_data), .rx_valid(rx_valid), .pcm_bclk(pcm_bclk),
        .pcm_sync(pcm_sync), .pcm_dout(pcm_dout),
        .pcm_dout_oe(pcm_dout_oe), .pcm_din(pcm_din)
    );
    pcm_codec_model u_pcm_codec_model (
        .pcm_bclk(pcm_bclk), .pcm_sync(pcm_sync),
        .pcm_dout(pcm_dout_oe ? pcm_dout : 1'bz),
        .send_word(codec_word), .pcm_din(pcm_din)
    );

    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk_word(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk_word

    task automatic tick(inout int n, input int lim);
        @(negedge clk);
        n++;
        if (n > lim) begin
            chk_word("timeout", 16'h0, 16'h1);
            close_out();
        end
    endtask : tick

    task automatic t_underrun;
        int n;
        n = 0;
        while (tx_underrun !== 1'b1)
            tick(n, 2000);
        tick(n, 2000);
        chk_word("underrun pulse", 16'h0, {15'h0, tx_underrun});
    endtask : t_underrun

    task automatic t_fill;
        int n;
        n = 0;
        @(posedge clk);
        while (n <= DEPTH) begin
            tx_data  <= TXW[n[1:0]];
            tx_valid <= 1'b1;
            @(posedge clk);
            if (tx_ready !== 1'b1)
                break;
            n++;
        end
        tx_valid <= 1'b0;
        chk_word("words taken", 16'(DEPTH), 16'(n));
    endtask : t_fill

    task automatic t_rx(input logic [15:0] w);
        int n;
        n = 0;
        codec_word <= w;
        repeat (2) begin
            tick(n, 30000);
            while (rx_valid !== 1'b1)
                tick(n, 30000);
        end
        chk_word("rx_data", w, rx_data);
        tick(n, 30000);
        chk_word("rx_valid", 16'h0, {15'h0, rx_valid});
        chk_word("rx_data held", w, rx_data);
    endtask : t_rx

    task automatic t_drain;
        int n;
        n = 0;
        while (u_pcm_codec_model.got.size() < DEPTH + 2)
            tick(n, 90000);
        chk_word("empty frame", 16'h0, u_pcm_codec_model.got[1]);
        for (int k = 0; k < DEPTH; k++)
            chk_word("line word", TXW[k], u_pcm_codec_model.got[k + 2]);
    endtask : t_drain

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_underrun();
        t_fill();
        t_rx(16'h8001);
        t_rx(16'h7ffe);
        t_drain();
        close_out();
    end
endmodule : tb_pcm_voice_master_port
